// *** hdl/cfmon_pkg.sv ***
package cfmon_pkg;
  // ---------------------------------------------------------------
  // Register map (byte addresses, one aligned word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_CAPTURE = 8'h0c;
  localparam logic [7:0] OFS_LOWER = 8'h10;
  localparam logic [7:0] OFS_UPPER = 8'h14;
  localparam logic [7:0] OFS_CLKSEL = 8'h18;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_RUNNING = 2;
  localparam int CTRL_SEL = 3;
  localparam int CTRL_DISCARD = 4;
  localparam int CTRL_ITV_EN = 5;
  localparam int ST_CAPTURE = 0;
  localparam int ST_SWITCH = 1;
  localparam int ST_FAULT = 2;
  localparam int ST_W = 3;
  localparam int CLK_A_LSB = 0;
  localparam int CLK_B_LSB = 8;
  localparam int CLK_CUR_LSB = 16;

  // ---------------------------------------------------------------
  // Reset values and encodings
  // ---------------------------------------------------------------
  localparam logic [15:0] LOWER_RST = 16'd1255;
  localparam logic [15:0] UPPER_RST = 16'd1750;
  localparam logic [7:0] SEL_24MHZ = 8'h00;
  localparam logic [7:0] SEL_32MHZ = 8'h02;
  localparam logic [7:0] SEL_48MHZ = 8'h04;
  localparam logic [7:0] CHOICE_A_RST = SEL_24MHZ;
  localparam logic [7:0] CHOICE_B_RST = SEL_32MHZ;
  localparam logic [ST_W-1:0] MASK_RST = 3'h0;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int MCLK_HZ = 25000000;
  localparam int DEB_TIME_US = 10000;
  localparam int DEB_CYC = DEB_TIME_US * (MCLK_HZ / 1000000);
  localparam int BLINK_TIME_MS = 250;
  localparam int BLINK_CYC = BLINK_TIME_MS * (MCLK_HZ / 1000);

  typedef enum logic [1:0] {
    CFMON_IDLE = 2'b00,
    CFMON_SETTLE = 2'b01,
    CFMON_DEBOUNCE = 2'b11
  } cfmon_state_e;

  typedef struct packed {
    logic [15:0] lower;
    logic [15:0] upper;
  } cfmon_win_s;
endpackage : cfmon_pkg

// *** hdl/cfmon_top.sv ***
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
// Overview of operation
// - Counter counts fast oscillator ticks; low-speed 32.768 kHz input gives edges.
// - Writing one to the start bit zeroes the counter and starts counting.
// - Enable edge copies counter into capture register unless a start write, a press or a stop write lands in the same cycle; judged captures raise capture-done.
// - Counter clears to zero after every capture.
// - First capture after any start is discarded, later ones are judged.
// - First capture leaves no pending capture-done request behind.
// - In-window interval turns fault indicator off, out-of-window makes it blink.
// - Monitor idles until a switch event, then serves it; captures are handled outside the state sequence.
// - Divider select output carries one of two predefined choice values.
// - Switch event sets interval enable, waits one cycle for it to settle.
// - At debounce expiry switch high means no press, low confirms press.
// - Confirmed press stops, swaps count clock and restarts with discard.
// - Clock-select indicator lit on second choice, dark on first choice.
// - Window defaults to 1255 lower and 1750 upper count cycles.
// - Select encoding is 0x00 24 MHz, 0x02 32 MHz, 0x04 48 MHz.
module cfmon_top #(
  parameter int CNT_W = 16,
  parameter int DEB_CYCLES = cfmon_pkg::DEB_CYC,
  parameter int BLINK_CYCLES = cfmon_pkg::BLINK_CYC
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic fast_osc_clock_in,
  input wire logic ref_osc_in,
  input wire logic switch_pin_level_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic irq_out,
  output logic [7:0] fast_osc_divider_sel_out,
  output logic fault_indicator_out,
  output logic clock_sel_indicator_out
);

  // ---------------------------------------------------------------
  // Parameter checks
  // ---------------------------------------------------------------
  // Fewer than eleven bits cannot hold the default upper limit.
  if (CNT_W < 11 || CNT_W > 16) begin : g_bad_cnt_w
    $error("CNT_W must lie in 11..16");
  end
  if (DEB_CYCLES < 1 || BLINK_CYCLES < 1) begin : g_bad_timing
    $error("Timing counts must be at least one");
  end

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // A level is accepted only when stages two and three agree, which
  // filters a single metastable sample at the cost of one extra cycle.
  localparam int NPIN = 3;
  localparam int P_FAST = 0;
  localparam int P_REF = 1;
  localparam int P_SW = 2;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] lvl_ff;
  logic [NPIN-1:0] rise;
  logic [NPIN-1:0] fall;
  assign pin_raw = {switch_pin_level_in, ref_osc_in, fast_osc_clock_in};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      logic s1_ff;
      logic s2_ff;
      logic s3_ff;
      wire agree = (s2_ff == s3_ff);
      wire rst_lvl = (gi == P_SW);
      always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
          s1_ff <= rst_lvl;
          s2_ff <= rst_lvl;
          s3_ff <= rst_lvl;
          lvl_ff[gi] <= rst_lvl;
        end else begin
          s1_ff <= pin_raw[gi];
          s2_ff <= s1_ff;
          s3_ff <= s2_ff;
          if (agree) begin
            lvl_ff[gi] <= s3_ff;
          end
        end
      end
      assign rise[gi] = agree && s3_ff && !lvl_ff[gi];
      assign fall[gi] = agree && !s3_ff && lvl_ff[gi];
    end
  endgenerate

  wire count_tick = rise[P_FAST];
  wire enable_edge = rise[P_REF];
  wire switch_irq = fall[P_SW];

  // ---------------------------------------------------------------
  // APB slave decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a[7:2] == o[7:2]);
  endfunction : hit

  wire acc = psel_in && penable_in;
  wire wr = acc && pwrite_in;
  wire hit_ctrl = hit(paddr_in, cfmon_pkg::OFS_CTRL);
  wire hit_stat = hit(paddr_in, cfmon_pkg::OFS_STATUS);
  wire hit_mask = hit(paddr_in, cfmon_pkg::OFS_MASK);
  wire hit_cap = hit(paddr_in, cfmon_pkg::OFS_CAPTURE);
  wire hit_low = hit(paddr_in, cfmon_pkg::OFS_LOWER);
  wire hit_up = hit(paddr_in, cfmon_pkg::OFS_UPPER);
  wire hit_clk = hit(paddr_in, cfmon_pkg::OFS_CLKSEL);
  wire mapped = hit_ctrl || hit_stat || hit_mask || hit_cap || hit_low ||
                hit_up || hit_clk;
  wire sw_start = wr && hit_ctrl && pwdata_in[cfmon_pkg::CTRL_START];
  wire sw_stop = wr && hit_ctrl && pwdata_in[cfmon_pkg::CTRL_STOP];

  // ---------------------------------------------------------------
  // Registers and state
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic [CNT_W-1:0] cap_ff;
  logic ovf_ff;
  logic run_ff;
  logic discard_ff;
  logic sel_ff;
  logic itv_en_ff;
  logic blink_ff;
  logic phase_ff;
  logic [31:0] deb_ff;
  logic [31:0] blk_ff;
  logic [cfmon_pkg::ST_W-1:0] status_ff;
  logic [cfmon_pkg::ST_W-1:0] mask_ff;
  logic [7:0] choice_a_ff;
  logic [7:0] choice_b_ff;
  cfmon_pkg::cfmon_win_s win_ff;
  cfmon_pkg::cfmon_state_e state_ff;
  cfmon_pkg::cfmon_state_e nxt_state;

  // ---------------------------------------------------------------
  // Switch debounce sequence
  // ---------------------------------------------------------------
  wire deb_done = (state_ff == cfmon_pkg::CFMON_DEBOUNCE) &&
                  (deb_ff == 32'(DEB_CYCLES - 1));
  wire press = deb_done && !lvl_ff[P_SW];

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      cfmon_pkg::CFMON_IDLE: begin
        if (switch_irq) begin
          nxt_state = cfmon_pkg::CFMON_SETTLE;
        end
      end
      cfmon_pkg::CFMON_SETTLE: begin
        nxt_state = cfmon_pkg::CFMON_DEBOUNCE;
      end
      cfmon_pkg::CFMON_DEBOUNCE: begin
        if (deb_done) begin
          nxt_state = cfmon_pkg::CFMON_IDLE;
        end
      end
      default: begin
        nxt_state = cfmon_pkg::CFMON_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      state_ff <= cfmon_pkg::CFMON_IDLE;
      itv_en_ff <= 1'b0;
      deb_ff <= 32'h0000_0000;
    end else begin
      state_ff <= nxt_state;
      itv_en_ff <= (nxt_state != cfmon_pkg::CFMON_IDLE);
      if (state_ff == cfmon_pkg::CFMON_DEBOUNCE && !deb_done) begin
        deb_ff <= deb_ff + 32'h0000_0001;
      end else begin
        deb_ff <= 32'h0000_0000;
      end
    end
  end

  // ---------------------------------------------------------------
  // Capture counter and judgement
  // ---------------------------------------------------------------
  // A press restarts in the same cycle, so stop and start collapse
  // into one restart with the discard armed again.
  wire restart = sw_start || press;
  wire cap_evt = run_ff && enable_edge && !restart;
  wire judged = cap_evt && !discard_ff;
  wire in_win = !ovf_ff && (cnt_ff >= CNT_W'(win_ff.lower)) &&
                (cnt_ff <= CNT_W'(win_ff.upper));
  wire abnormal = judged && !in_win;

  always_comb begin
    nxt_cnt = cnt_ff;
    if (restart || cap_evt) begin
      nxt_cnt = '0;
    end else if (run_ff && count_tick) begin
      nxt_cnt = cnt_ff + CNT_W'(1);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      cnt_ff <= '0;
      cap_ff <= '0;
      ovf_ff <= 1'b0;
      run_ff <= 1'b0;
      discard_ff <= 1'b1;
      sel_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      if (restart) begin
        run_ff <= 1'b1;
        discard_ff <= 1'b1;
        ovf_ff <= 1'b0;
      end else if (sw_stop) begin
        run_ff <= 1'b0;
      end else if (cap_evt) begin
        cap_ff <= cnt_ff;
        discard_ff <= 1'b0;
        ovf_ff <= 1'b0;
      end else if (run_ff && count_tick && (&cnt_ff)) begin
        ovf_ff <= 1'b1;
      end
      if (press) begin
        sel_ff <= !sel_ff;
      end
    end
  end

  // ---------------------------------------------------------------
  // Fault indicator blink
  // ---------------------------------------------------------------
  // Phase rests high, so a new fault lights the lamp at once.
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      blink_ff <= 1'b0;
      phase_ff <= 1'b0;
      blk_ff <= 32'h0000_0000;
    end else begin
      if (judged) begin
        blink_ff <= abnormal;
      end
      if (!blink_ff) begin
        phase_ff <= 1'b1;
        blk_ff <= 32'h0000_0000;
      end else if (blk_ff == 32'(BLINK_CYCLES - 1)) begin
        phase_ff <= !phase_ff;
        blk_ff <= 32'h0000_0000;
      end else begin
        blk_ff <= blk_ff + 32'h0000_0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // Software registers and sticky events
  // ---------------------------------------------------------------
  // The discarded first capture never sets the capture-done bit, so
  // no request is left pending into the judged measurements.
  logic [cfmon_pkg::ST_W-1:0] evt;
  logic [cfmon_pkg::ST_W-1:0] w1c;
  always_comb begin
    evt = '0;
    evt[cfmon_pkg::ST_CAPTURE] = judged;
    evt[cfmon_pkg::ST_SWITCH] = press;
    evt[cfmon_pkg::ST_FAULT] = abnormal;
    w1c = (wr && hit_stat) ? pwdata_in[cfmon_pkg::ST_W-1:0] : '0;
  end

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      status_ff <= '0;
      mask_ff <= cfmon_pkg::MASK_RST;
      win_ff.lower <= cfmon_pkg::LOWER_RST;
      win_ff.upper <= cfmon_pkg::UPPER_RST;
      choice_a_ff <= cfmon_pkg::CHOICE_A_RST;
      choice_b_ff <= cfmon_pkg::CHOICE_B_RST;
    end else begin
      status_ff <= (status_ff & ~w1c) | evt;
      if (wr && hit_mask) begin
        mask_ff <= pwdata_in[cfmon_pkg::ST_W-1:0];
      end
      if (wr && hit_low) begin
        win_ff.lower <= pwdata_in[15:0];
      end
      if (wr && hit_up) begin
        win_ff.upper <= pwdata_in[15:0];
      end
      if (wr && hit_clk) begin
        choice_a_ff <= pwdata_in[cfmon_pkg::CLK_A_LSB +: 8];
        choice_b_ff <= pwdata_in[cfmon_pkg::CLK_B_LSB +: 8];
      end
    end
  end

  // ---------------------------------------------------------------
  // Read mux and outputs
  // ---------------------------------------------------------------
  wire [7:0] cur_sel = sel_ff ? choice_b_ff : choice_a_ff;
  logic [31:0] ctrl_rd;
  logic [31:0] clk_rd;
  always_comb begin
    ctrl_rd = 32'h0000_0000;
    ctrl_rd[cfmon_pkg::CTRL_RUNNING] = run_ff;
    ctrl_rd[cfmon_pkg::CTRL_SEL] = sel_ff;
    ctrl_rd[cfmon_pkg::CTRL_DISCARD] = discard_ff;
    ctrl_rd[cfmon_pkg::CTRL_ITV_EN] = itv_en_ff;
    clk_rd = 32'h0000_0000;
    clk_rd[cfmon_pkg::CLK_A_LSB +: 8] = choice_a_ff;
    clk_rd[cfmon_pkg::CLK_B_LSB +: 8] = choice_b_ff;
    clk_rd[cfmon_pkg::CLK_CUR_LSB +: 8] = cur_sel;
  end

  wire [31:0] rd_mux =
    hit_ctrl ? ctrl_rd :
    hit_stat ? {29'h0000_0000, status_ff} :
    hit_mask ? {29'h0000_0000, mask_ff} :
    hit_cap ? 32'(cap_ff) :
    hit_low ? {16'h0000, win_ff.lower} :
    hit_up ? {16'h0000, win_ff.upper} :
    hit_clk ? clk_rd : 32'h0000_0000;

  assign prdata_out = (acc && !pwrite_in) ? rd_mux : 32'h0000_0000;
  assign pready_out = 1'b1;
  assign pslverr_out = acc && !mapped;
  assign irq_out = |(status_ff & mask_ff);
  assign fast_osc_divider_sel_out = cur_sel;
  assign fault_indicator_out = blink_ff && phase_ff;
  assign clock_sel_indicator_out = sel_ff;

endmodule : cfmon_top

// *** sim/cfmon_osc_model.sv ***
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Count clock and reference oscillator
// ---------------------------------------------------------------
// The reference rises on a falling count edge, half a count period
// away from any counted edge, so no tick is lost at capture time.
module cfmon_osc_model #(
  parameter int HALF_NS = 200
) (
  input wire logic [15:0] ticks_in,
  output logic fast_osc_clock_out,
  output logic ref_osc_out
);
  int cnt = 0;
  logic fclk_q = 1'b0;
  logic ref_q = 1'b0;
  assign fast_osc_clock_out = fclk_q;
  assign ref_osc_out = ref_q;
  always #(HALF_NS) fclk_q = ~fclk_q;
  always @(negedge fclk_q) begin
    if (cnt >= int'(ticks_in) - 1) begin
      cnt = 0;
      ref_q = 1'b1;
    end else begin
      cnt = cnt + 1;
    end
    if (cnt == int'(ticks_in) / 2) begin
      ref_q = 1'b0;
    end
  end
endmodule : cfmon_osc_model

// *** sim/cfmon_chk.sv ***
`timescale 1ns/1ps
module cfmon_chk #(
  parameter int BLINK_CYCLES = 8
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic ref_osc_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic irq_out,
  input wire logic [7:0] fast_osc_divider_sel_out,
  input wire logic fault_indicator_out,
  input wire logic clock_sel_indicator_out
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Changes of the fault lamp near a reference edge may come from a
  // capture, so the blink period is only judged away from them.
  logic [31:0] flt_age;
  logic [7:0] ref_hist;
  logic acc;
  logic wr_acc;
  logic wr_clksel;
  logic ref_quiet;
  assign acc = psel_in && penable_in;
  assign wr_acc = acc && pwrite_in;
  assign wr_clksel = wr_acc && paddr_in[7:2] == cfmon_pkg::OFS_CLKSEL[7:2];
  assign ref_quiet = ref_hist == 8'h00 || ref_hist == 8'hff;
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      flt_age <= 32'h0;
    end else begin
      flt_age <= $changed(fault_indicator_out) ? 32'h0 : flt_age + 32'h1;
    end
    ref_hist <= {ref_hist[6:0], ref_osc_in};
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  a_reset_quiet: assert property (disable iff (1'b0)
    !nrst_in |=> !fault_indicator_out && !clock_sel_indicator_out &&
    !irq_out && fast_osc_divider_sel_out == 8'h00)
    else $error("outputs not quiet after reset");
  a_unmapped_err: assert property (
    acc && paddr_in[7:2] > 6'h06 |-> pslverr_out && prdata_out == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (acc && paddr_in[7:2] <= 6'h06 |-> !pslverr_out)
    else $error("mapped access refused");
  a_rdata_idle: assert property (!(acc && !pwrite_in) |-> prdata_out == 32'h0)
    else $error("read data outside read access");
  a_pready_high: assert property (psel_in |-> pready_out)
    else $error("ready low during transfer");
  a_mask_off: assert property (wr_acc && pwdata_in[2:0] == 3'h0 &&
    paddr_in[7:2] == cfmon_pkg::OFS_MASK[7:2] |=> !irq_out)
    else $error("interrupt with all sources masked");
  a_div_cause: assert property ($changed(fast_osc_divider_sel_out)
    |-> $changed(clock_sel_indicator_out) || $past(wr_clksel))
    else $error("divider select changed without cause");
  a_blink_period: assert property ($changed(fault_indicator_out)
    && ref_quiet |-> flt_age == BLINK_CYCLES - 1)
    else $error("fault lamp toggled off its period");
endmodule : cfmon_chk
bind cfmon_top cfmon_chk #(.BLINK_CYCLES(BLINK_CYCLES)) u_chk (
  .mclk_in(mclk_in), .nrst_in(nrst_in), .ref_osc_in(ref_osc_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
  .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .irq_out(irq_out),
  .fast_osc_divider_sel_out(fast_osc_divider_sel_out),
  .fault_indicator_out(fault_indicator_out),
  .clock_sel_indicator_out(clock_sel_indicator_out));

// *** sim/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  // ---------------------------------------------------------------
  // Bench, partner and design
  // ---------------------------------------------------------------
  logic mclk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic sw = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic [15:0] ticks = 16'h0019;
  logic [31:0] prd;
  logic [31:0] rv;
  logic re;
  logic [7:0] div;
  logic rdy, err, irq, fclk, rclk, flt, sel;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  always #20 mclk_in = ~mclk_in;
  cfmon_osc_model u_osc (.ticks_in(ticks), .fast_osc_clock_out(fclk),
    .ref_osc_out(rclk));
  cfmon_top #(.DEB_CYCLES(20), .BLINK_CYCLES(8)) uut (
    .mclk_in(mclk_in), .nrst_in(nrst_in), .fast_osc_clock_in(fclk),
    .ref_osc_in(rclk), .switch_pin_level_in(sw), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd),
    .prdata_out(prd), .pready_out(rdy), .pslverr_out(err), .irq_out(irq),
    .fast_osc_divider_sel_out(div), .fault_indicator_out(flt),
    .clock_sel_indicator_out(sel));
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  // A hang anywhere ends the run as a failure.
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge mclk_in);
    pen <= 1'b1;
    @(posedge mclk_in);
    while (rdy !== 1'b1) @(posedge mclk_in);
    rv = prd;
    re = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic wait_irq;
    // A clearing write lands at the edge that ends it, so look one on.
    @(posedge mclk_in);
    for (int i = 0; i < 3000 && irq !== 1'b1; i++) @(posedge mclk_in);
    chk(irq, 1'b1);
  endtask : wait_irq
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    apb(1'b0, cfmon_pkg::OFS_LOWER, 32'h0);
    chk(rv, 32'h4e7);
    apb(1'b0, cfmon_pkg::OFS_UPPER, 32'h0);
    chk(rv, 32'h6d6);
    apb(1'b0, cfmon_pkg::OFS_CLKSEL, 32'h0);
    chk(rv, 32'h200);
    apb(1'b0, cfmon_pkg::OFS_CTRL, 32'h0);
    chk(rv, 32'h10);
    chk({flt, sel, div}, 10'h0);
    apb(1'b0, 8'h1c, 32'h0);
    chk(re, 1'b1);
    chk(rv, 32'h0);
  endtask : t_reset
  task automatic t_measure;
    apb(1'b1, cfmon_pkg::OFS_LOWER, 32'h14);
    apb(1'b1, cfmon_pkg::OFS_UPPER, 32'h1e);
    apb(1'b1, cfmon_pkg::OFS_MASK, 32'h1);
    apb(1'b1, cfmon_pkg::OFS_CTRL, 32'h1);
    apb(1'b0, cfmon_pkg::OFS_CTRL, 32'h0);
    chk(rv[4:2], 3'h5);
    for (int i = 0; i < 200 && rv[4] !== 1'b0; i++) begin
      apb(1'b0, cfmon_pkg::OFS_CTRL, 32'h0);
    end
    apb(1'b0, cfmon_pkg::OFS_STATUS, 32'h0);
    chk(rv[0], 1'b0);
    wait_irq();
    apb(1'b0, cfmon_pkg::OFS_CAPTURE, 32'h0);
    chk(rv[15:0], ticks);
    apb(1'b1, cfmon_pkg::OFS_STATUS, 32'h7);
    apb(1'b1, cfmon_pkg::OFS_MASK, 32'h0);
    repeat (300) @(posedge mclk_in);
    chk(irq, 1'b0);
    apb(1'b0, cfmon_pkg::OFS_STATUS, 32'h0);
    chk(rv[0], 1'b1);
    apb(1'b1, cfmon_pkg::OFS_MASK, 32'h1);
    @(posedge mclk_in);
    chk(irq, 1'b1);
  endtask : t_measure
  task automatic t_window;
    logic [15:0] tv [5] = '{16'h14, 16'h13, 16'h1e, 16'h1f, 16'h19};
    int hi;
    for (int i = 0; i < 5; i++) begin
      ticks <= tv[i];
      apb(1'b1, cfmon_pkg::OFS_STATUS, 32'h7);
      wait_irq();
      apb(1'b1, cfmon_pkg::OFS_STATUS, 32'h7);
      wait_irq();
      apb(1'b0, cfmon_pkg::OFS_CAPTURE, 32'h0);
      chk(rv[15:0], tv[i]);
      apb(1'b0, cfmon_pkg::OFS_STATUS, 32'h0);
      chk(rv[2], i % 2);
      hi = 0;
      repeat (16) @(posedge mclk_in) hi = hi + int'(flt);
      chk(hi > 0 && hi < 16, i % 2);
    end
    chk(flt, 1'b0);
  endtask : t_window
  task automatic t_switch;
    apb(1'b1, cfmon_pkg::OFS_CLKSEL, 32'h400);
    apb(1'b1, cfmon_pkg::OFS_MASK, 32'h2);
    chk(div, 8'h00);
    sw <= 1'b0;
    repeat (6) @(posedge mclk_in);
    sw <= 1'b1;
    repeat (40) @(posedge mclk_in);
    apb(1'b0, cfmon_pkg::OFS_STATUS, 32'h0);
    chk({rv[1], sel}, 2'h0);
    for (int i = 0; i < 2; i++) begin
      sw <= 1'b0;
      repeat (10) @(posedge mclk_in);
      apb(1'b0, cfmon_pkg::OFS_CTRL, 32'h0);
      chk(rv[5], 1'b1);
      wait_irq();
      sw <= 1'b1;
      apb(1'b0, cfmon_pkg::OFS_CTRL, 32'h0);
      chk(rv[4:2], {1'b1, i == 0, 1'b1});
      chk(sel, i == 0);
      chk(div, i == 0 ? 8'h04 : 8'h00);
      apb(1'b1, cfmon_pkg::OFS_STATUS, 32'h7);
      repeat (40) @(posedge mclk_in);
    end
    apb(1'b1, cfmon_pkg::OFS_CTRL, 32'h2);
    apb(1'b0, cfmon_pkg::OFS_CTRL, 32'h0);
    chk(rv[2], 1'b0);
  endtask : t_switch
  initial begin
    repeat (6) @(posedge mclk_in);
    nrst_in <= 1'b1;
    t_reset();
    t_measure();
    t_window();
    t_switch();
    tally_and_finish();
  end
endmodule : testbench
